// ---- src/stepper_params.svh ----
// constants for the stepper interface control block
// assumes a 50 mhz system clock; included by design files only
`ifndef STEPPER_PARAMS_SVH
`define STEPPER_PARAMS_SVH
`define CLK_PERIOD_NS      20
`define IDLE_OFF_TIME_MS   500
`define IDLE_OFF_CYCLES    ((`IDLE_OFF_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define RES_BINARY_BIT     3
`define RES_FULL_CODE      4'he
`define RES_DEGREE_CODE    4'hf
`define RES_DEC_LAST       3'h4
`define PHASE_ACC_W        16
`define FULL_STEP_SPAN     17'h04000
`define QUARTER_MASK       16'h3fff
`endif

// ---- src/stepper_pkg.sv ----
// types shared by the stepper interface control block
// assumes nothing beyond a sv compiler
package stepper_pkg;
  // decoded resolution
  typedef struct packed {
    logic        valid;
    logic [8:0]  usteps;
  } res_info_t;
  // status presented outward
  typedef struct packed {
    logic fault;
    logic overtemp;
    logic at_full_step;
  } drv_status_t;
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_RUN   = 3'b010,
    ST_HALT  = 3'b100
  } drv_state_t;
endpackage

// ---- src/res_decode.sv ----
// microstep resolution decoder
// assumes a static four-bit switch setting
`timescale 1ns/100ps
`default_nettype none
`include "stepper_params.svh"
module res_decode
  import stepper_pkg::*;
(
  // switch setting
  input  wire logic [3:0] step_resolution_select,
  // decoded count
  output res_info_t       res
);
  logic [2:0] low;
  assign low = step_resolution_select[2:0];
  // binary, decimal, full step and degree tables
  always_comb begin
    res = '{valid: 1'b1, usteps: 9'h000};
    if (!step_resolution_select[`RES_BINARY_BIT]) begin
      res.usteps = 9'(9'h002 << low);
    end else if (step_resolution_select == `RES_FULL_CODE) begin
      res.usteps = 9'h001;
    end else if (step_resolution_select == `RES_DEGREE_CODE) begin
      res.usteps = 9'h0b4;
    end else begin
      unique case (low)
        3'h0: res.usteps = 9'h005;
        3'h1: res.usteps = 9'h00a;
        3'h2: res.usteps = 9'h019;
        3'h3: res.usteps = 9'h032;
        3'h4: res.usteps = 9'h07d;
        default: res = '{valid: 1'b0, usteps: 9'h000}; // unlisted code
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- src/stepper_interface_control.sv ----
// step/direction front end of a stepper driver board
// assumes all inputs synchronous to clk; open-drain pins resolved outside
`timescale 1ns/100ps
`default_nettype none
`include "stepper_params.svh"
// Overview of operation
// - auto-disable switches phases off after idle
// - idle-hold keeps phases enabled indefinitely
// - binary resolution is two to bits+1
// - decimal, full-step and degree resolution codes
// - fault latched until power or reset toggle
// - phase to ground short raises fault while running
// - fault terminal open-drain, low on fault
// - fault lamp follows fault indication
// - over-temperature halts without fault outputs
// - full-step terminal open-drain, low at full step
module stepper_interface_control
  import stepper_pkg::*;
#(
  parameter int unsigned IDLE_OFF_CYCLES = `IDLE_OFF_CYCLES
)(
  // system
  input  wire logic        clk,
  input  wire logic        rst,
  // controller inputs
  input  wire logic        step_clock,
  input  wire logic        direction,
  input  wire logic        phase_enable,
  input  wire logic        reset_n,
  // board setup
  input  wire logic [3:0]  step_resolution_select,
  input  wire logic        idle_auto_disable,
  input  wire logic        idle_hold_enabled,
  // sensed conditions
  input  wire logic        phase_ground_short,
  input  wire logic        over_temp,
  // power stage
  output logic             phase_out_en,
  output logic [15:0]      phase_angle,
  // open-drain terminals and lamp
  output logic             fault_n_o,
  output logic             fault_n_oe,
  output logic             full_step_n_o,
  output logic             full_step_n_oe,
  output logic             fault_lamp,
  // status
  output logic             overtemp_halt,
  output logic             res_invalid
);
  localparam int unsigned CNT_W = $clog2(IDLE_OFF_CYCLES + 1);

  // elaboration checks; a zero count would switch the phases off at once
  if (IDLE_OFF_CYCLES < 1) begin : g_bad_idle
    $error("idle off count must be at least one");
  end
  // the full-step test masks low angle bits, so mask and span must agree
  if (`QUARTER_MASK != 16'(`FULL_STEP_SPAN - 17'h00001)) begin : g_bad_span
    $error("full step mask does not match the full step span");
  end
  // the angle port carries the whole accumulator
  if (`PHASE_ACC_W != $bits(phase_angle)) begin : g_bad_acc
    $error("angle accumulator must match the phase angle port");
  end

  // decoded switch setting, latched causes and state
  res_info_t   res;
  drv_status_t stat_r;
  drv_state_t  state_r;
  drv_state_t  state_nxt;
  // step detection and idle timing
  logic        step_d_r;
  logic        step_rise;
  logic [CNT_W-1:0] idle_cnt_r;
  logic        idle_off_r;
  // position
  logic [`PHASE_ACC_W-1:0] angle_r;
  logic [16:0] incr;
  logic        run_ok;

  res_decode u_res_decode (
    .step_resolution_select (step_resolution_select),
    .res                    (res)
  );

  // step edge; the step input is the motion clock
  // the detector rests low like the idle step line, so reset makes no edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_d_r <= 1'b0;
    end else begin
      step_d_r <= step_clock;
    end
  end
  assign step_rise = step_clock && !step_d_r;

  // reset pin low holds reset; fault or heat halts until a reset toggle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET: if (reset_n) state_nxt = ST_RUN;
      ST_RUN: begin
        if (!reset_n) state_nxt = ST_RESET;
        else if (phase_ground_short || over_temp) state_nxt = ST_HALT;
      end
      ST_HALT: if (!reset_n) state_nxt = ST_RESET;
      default: state_nxt = ST_RESET;
    endcase
  end
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // latched causes; only reset clears, so a power cycle also clears
  // a short seen while the reset pin is low is dropped: the hold wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
    end else if (state_nxt == ST_RESET) begin
      stat_r.fault    <= 1'b0;
      stat_r.overtemp <= 1'b0;
      stat_r.at_full_step <= (angle_r & `QUARTER_MASK) == '0;
    end else begin
      if (state_r == ST_RUN && phase_ground_short) stat_r.fault <= 1'b1;
      if (state_r == ST_RUN && over_temp && !phase_ground_short) begin
        stat_r.overtemp <= 1'b1;
      end
      stat_r.at_full_step <= (angle_r & `QUARTER_MASK) == '0;
    end
  end

  // idle counter; restarts on every step pulse and rests at the limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt_r <= '0;
    end else if (step_rise || state_r != ST_RUN) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != CNT_W'(IDLE_OFF_CYCLES - 1)) begin
      idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end

  // idle flag; set once the count runs out, cleared by the next step
  // resting the counter at the limit keeps it from wrapping and re-enabling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_off_r <= 1'b0;
    end else if (step_rise || state_r != ST_RUN) begin
      idle_off_r <= 1'b0;
    end else if (idle_cnt_r == CNT_W'(IDLE_OFF_CYCLES - 1)) begin
      idle_off_r <= 1'b1;
    end
  end

  // microstep position; one full step spans a quarter electrical turn
  // decimal and degree counts do not divide the span, so the increment is
  // truncated and those resolutions drift off exact full-step positions
  assign incr = 17'(`FULL_STEP_SPAN / (res.usteps == 9'h000 ? 17'h1 : 17'(res.usteps)));
  assign run_ok = state_r == ST_RUN && res.valid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      angle_r <= '0;
    end else if (run_ok && phase_enable && step_rise) begin
      if (direction) angle_r <= angle_r + incr[15:0];
      else           angle_r <= angle_r - incr[15:0];
    end
  end
  // angle leaves straight from its register; top two bits count full steps
  assign phase_angle = angle_r;

  // phase enable: auto-disable wins only when selected and hold is not
  // hold wins when both read high, since keeping torque is the safer side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_out_en <= 1'b0;
    end else begin
      phase_out_en <= run_ok && phase_enable
                      && !(idle_auto_disable && !idle_hold_enabled && idle_off_r);
    end
  end

  // terminals: drive low when active, release otherwise
  // every terminal leaves a flip-flop, so no decode glitch reaches a pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_n_o  <= 1'b0;
      fault_n_oe <= 1'b0;
      fault_lamp <= 1'b0;
    end else begin
      fault_n_o  <= 1'b0;
      fault_n_oe <= stat_r.fault;
      fault_lamp <= stat_r.fault;
    end
  end

  // full-step terminal pulls low while the rotor sits on a full step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      full_step_n_o  <= 1'b0;
      full_step_n_oe <= 1'b0;
    end else begin
      full_step_n_o  <= 1'b0;
      full_step_n_oe <= stat_r.at_full_step;
    end
  end

  // plain status; heat stops motion but never touches lamp or terminal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overtemp_halt <= 1'b0;
      res_invalid   <= 1'b0;
    end else begin
      overtemp_halt <= stat_r.overtemp;
      res_invalid   <= !res.valid;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/stepper_interface_control_asserts.sv ----
// assertions on the stepper interface control ports
// assumes one clk domain; bound onto the design top below
`timescale 1ns/100ps
`default_nettype none
module stepper_interface_control_asserts #(
  parameter int unsigned IDLE_OFF_CYCLES = 20
)(
  // inputs of the block, grouped to save space
  input wire logic clk, rst, step_clock, reset_n, phase_enable, over_temp,
  input wire logic idle_auto_disable, idle_hold_enabled, phase_ground_short,
  input wire logic [3:0] step_resolution_select,
  // outputs of the block
  input wire logic phase_out_en, fault_n_o, fault_n_oe, full_step_n_o,
  input wire logic fault_lamp, overtemp_halt, full_step_n_oe,
  input wire logic [15:0] phase_angle
);
  int unsigned idle_cnt_r;
  // cycles since the step line was high; saturates so it never wraps
  always_ff @(posedge clk or posedge rst)
    if (rst) idle_cnt_r <= 0;
    else if (step_clock) idle_cnt_r <= 0;
    else if (idle_cnt_r < IDLE_OFF_CYCLES + 8) idle_cnt_r <= idle_cnt_r + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // four quiet samples leave room for the pipeline after the last step
  sequence quiet4; (!step_clock && reset_n)[*4]; endsequence
  sequence short2; (phase_ground_short && reset_n && !overtemp_halt)[*2]; endsequence
  sequence held3;
    (idle_hold_enabled && phase_enable && reset_n && !over_temp && !phase_ground_short
      && $stable(step_resolution_select))[*3];
  endsequence
  a_od_data_low: assert property (!fault_n_o && !full_step_n_o)
    else $error("open drain data high");
  a_lamp_follows: assert property (fault_lamp == fault_n_oe)
    else $error("lamp and terminal differ");
  a_short_faults: assert property (short2 |-> ##[0:3] fault_n_oe)
    else $error("short not flagged");
  a_fault_latched: assert property (fault_lamp && reset_n && $past(reset_n)
    && $past(reset_n, 2) && $past(reset_n, 3) |=> fault_lamp) else $error("fault lost");
  a_lamp_cause: assert property ($rose(fault_lamp) |-> $past(phase_ground_short)
    || $past(phase_ground_short, 2) || $past(phase_ground_short, 3)) else $error("lamp no short");
  a_temp_halts: assert property ((over_temp && reset_n && !fault_lamp)[*2]
    |-> ##[0:3] overtemp_halt) else $error("no temp halt");
  a_idle_off: assert property (idle_auto_disable && !idle_hold_enabled
    && idle_cnt_r == IDLE_OFF_CYCLES + 3 |-> !phase_out_en) else $error("idle not off");
  a_hold_on: assert property (held3 ##0 phase_out_en |=> phase_out_en)
    else $error("hold dropped");
  a_step_quiet: assert property (quiet4 |=> $stable(phase_angle))
    else $error("angle moved");
  a_full_step_map: assert property (!$past(rst) && !$past(rst, 2)
    |-> full_step_n_oe == ($past(phase_angle[13:0], 2) == 14'h0)) else $error("full step flag wrong");
endmodule
bind stepper_interface_control stepper_interface_control_asserts
  #(.IDLE_OFF_CYCLES(IDLE_OFF_CYCLES)) chk (.*);
`default_nettype wire

// ---- testbench/step_source.sv ----
// behavioural motion controller issuing step pulses
// assumes a count loaded for one cycle by the bench
`timescale 1ns/100ps
`default_nettype none
module step_source (
  // bench request
  input  wire logic       clk,
  input  wire logic       load,
  input  wire logic [7:0] n,
  // step line
  output logic            step_clock
);
  int   left = 0;
  logic hi   = 1'b0;
  // one high and one low cycle per step keeps the line low between rises
  always @(posedge clk) begin
    hi <= !hi && left > 0;
    if (load) left <= n;
    else if (!hi && left > 0) left <= left - 1;
  end
  // line moves on the falling edge, away from the sampling edge
  always @(negedge clk) step_clock <= hi;
endmodule
`default_nettype wire

// ---- testbench/stepper_interface_control_test.sv ----
// self-checking bench for the stepper interface control block
// assumes the step source model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module stepper_interface_control_test;
  logic clk = 1'b0, rst = 1'b1, direction = 1'b0, phase_enable = 1'b1, reset_n = 1'b1;
  logic idle_auto_disable = 1'b0, idle_hold_enabled = 1'b1;
  logic phase_ground_short = 1'b0, over_temp = 1'b0, load = 1'b0;
  logic [3:0] step_resolution_select = 4'h0;
  logic [7:0] n_steps = 8'h0;
  logic step_clock, phase_out_en, fault_n_o, fault_n_oe, full_step_n_o, full_step_n_oe;
  logic fault_lamp, overtemp_halt, res_invalid;
  logic [15:0] phase_angle, exp_angle = 16'h0;
  logic [31:0] seed = 32'h0000e609;
  int err_total = 0, n_tests = 0, u;
  always #10 clk = ~clk;
  step_source src (.clk(clk), .load(load), .n(n_steps), .step_clock(step_clock));
  stepper_interface_control #(.IDLE_OFF_CYCLES(20)) DUT (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // microsteps per full step; zero marks an unlisted switch code
  function automatic int usteps(input logic [3:0] s);
    if (!s[3]) return 2 << s[2:0];
    case (s[2:0])
      3'h0: return 5;
      3'h1: return 10;
      3'h2: return 25;
      3'h3: return 50;
      3'h4: return 125;
      3'h6: return 1;
      3'h7: return 180;
      default: return 0;
    endcase
  endfunction
  task cyc(input int k); repeat (k) @(negedge clk); endtask
  task run(input logic [7:0] k); load = 1; n_steps = k; cyc(1); load = 0; cyc(2 * k + 6); endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task toggle_reset; reset_n = 0; cyc(3); reset_n = 1; cyc(4); endtask
  task summarize;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hard bound on the whole run
  initial begin repeat (3000) @(posedge clk); err_total++; summarize; end
  initial begin
    cyc(12); rst = 0; cyc(3);
    chk(16'(full_step_n_oe), 16'h1);
    // every switch code, three steps each in a random sense
    for (int s = 0; s < 16; s++) begin
      step_resolution_select = s[3:0];
      seed = xs(seed);
      direction = seed[0];
      cyc(3);
      run(3);
      u = usteps(s[3:0]);
      if (u != 0) exp_angle = direction ? exp_angle + 16'(3 * (16384 / u))
                                        : exp_angle - 16'(3 * (16384 / u));
      chk(phase_angle, exp_angle);
      chk(16'(res_invalid), 16'(u == 0));
      chk(16'(full_step_n_oe), 16'(exp_angle[13:0] == 14'h0));
    end
    phase_ground_short = 1; cyc(2); phase_ground_short = 0; cyc(4);
    chk(16'({fault_lamp, fault_n_oe, fault_n_o}), 16'h6);
    run(2); chk(16'(fault_lamp), 16'h1);
    chk(phase_angle, exp_angle);
    toggle_reset; chk(16'({fault_lamp, fault_n_oe}), 16'h0);
    over_temp = 1; cyc(2); over_temp = 0; cyc(4);
    chk(16'({overtemp_halt, fault_lamp, fault_n_oe}), 16'h4);
    toggle_reset; chk(16'(overtemp_halt), 16'h0);
    phase_enable = 0; run(2); chk(16'(phase_out_en), 16'h0);
    chk(phase_angle, exp_angle);
    phase_enable = 1;
    run(1); cyc(40); chk(16'(phase_out_en), 16'h1);
    idle_hold_enabled = 0; idle_auto_disable = 1;
    run(1); chk(16'(phase_out_en), 16'h1);
    cyc(40); chk(16'(phase_out_en), 16'h0);
    summarize;
  end
endmodule
`default_nettype wire
